//--- gds_pkg.sv
// Package for the pad I/O logic block: register map, field layouts, modes and delay limits.
// Assumes one core clock that also serves as the serializer fast clock.
package gds_pkg;
    localparam int GDS_ADDR_W = 4;
    localparam int GDS_DATA_W = 32;
    localparam logic [3:0] GDS_CFG_ADDR = 4'h0;
    localparam logic [3:0] GDS_DLY_ADDR = 4'h4;
    localparam logic [3:0] GDS_STAT_ADDR = 4'h8;

    localparam int GDS_NARROW_STEPS = 16;
    localparam int GDS_WIDE_STEPS = 64;
    localparam int GDS_DYN_STEPS = 64;
    localparam int GDS_SER_WIDTH = 4;
    localparam int GDS_IN_LINE_DEPTH = GDS_NARROW_STEPS + GDS_DYN_STEPS;
    localparam int GDS_OUT_LINE_DEPTH = GDS_WIDE_STEPS;
    localparam logic [5:0] GDS_NARROW_MAX = 6'h0f;
    localparam logic [5:0] GDS_WIDE_MAX = 6'h3f;

    localparam logic [2:0] GDS_BYP_GLOBAL = 3'h0;
    localparam logic [2:0] GDS_BYP_REGIONAL = 3'h1;
    localparam logic [2:0] GDS_BYP_SYNTH_REF = 3'h2;
    localparam logic [2:0] GDS_BYP_SYNTH_FB = 3'h3;
    localparam logic [2:0] GDS_BYP_VREF = 3'h4;
    localparam int GDS_BYP_TARGETS = 5;

    typedef enum logic [1:0] {
        GDS_MODE_SINGLE,
        GDS_MODE_DOUBLE,
        GDS_MODE_SERDES,
        GDS_MODE_BYPASS
    } gds_mode_t;

    // Configuration word, bit 0 at the bottom (mode in [1:0], bypass target in [15:13])
    typedef struct packed {
        logic [2:0] bypass_target;
        logic dyn_delay_en;
        logic resync;
        logic out_invert;
        logic oe_fall;
        logic out_fall;
        logic in_fall;
        logic oe_reg;
        logic out_reg;
        logic in_reg;
        logic diff;
        logic high_speed;
        gds_mode_t mode;
    } gds_cfg_t;
    localparam gds_cfg_t GDS_CFG_RESET = '0;

    // Delay word: input static [5:0], output static [13:8], dynamic start [21:16]
    typedef struct packed {
        logic [5:0] dyn_init;
        logic [1:0] rsv1;
        logic [5:0] out_static;
        logic [1:0] rsv0;
        logic [5:0] in_static;
    } gds_dly_t;
    localparam gds_dly_t GDS_DLY_RESET = '0;
    localparam logic [21:0] GDS_DLY_WMASK = 22'h3f3f3f;

    typedef struct packed {
        logic p_out;
        logic p_oe;
        logic n_out;
        logic n_oe;
    } gds_pad_drive_t;

    typedef struct packed {
        logic [GDS_ADDR_W-1:0] addr;
        logic [GDS_DATA_W-1:0] wr_data;
        logic wr;
        logic rd;
    } gds_bus_req_t;
endpackage : gds_pkg

//--- gds_pad_logic.sv
// Pad I/O logic between core fabric and one pad pair: registers, double rate, 1:4 serdes,
// static and dynamic delay chains, bypass input tap.
// Assumes clk is the fast bit clock; launch and capture edges are alternate clk cycles.
// Inputs are synchronous to clk; the pad buffer resolves the three-signal pins.

// Functional notes
// - Narrow pads give 16-step static in/out delay
// - Differential receive: 64 steps, static excludes dynamic
// - Differential transmit: 64-step static output delay
// - Dynamic delay 64 steps, input path only
// - Differential delays act on positive leg only
// - Plain mode uses bit zero both ways
// - Double rate input: rise bit0, fall bit1
// - Double rate output: bit0 rise, bit1 fall
// - Deserializer: earliest bit on bit 0
// - Serializer: bit 0 first, bit 3 last
// - High-voltage bypass: synth reference, unregistered only
// - High-speed bypass: five targets, unregistered only
// - Output enable optionally registered on launch
// - Delay moves only when enabled, direction
// - Delay reset restores initial step
// - Launch clocks output/enable, capture clocks input
// - Separate fast clocks for serializer paths; here the one clk serves both
// - Pair is two pins or one differential
// - Serdes full rate, one bit per clock
// - Resync holds fall sample half cycle
// - Edge selectable registers, output inversion on registered plain and double rate output
module gds_pad_logic (
    input wire logic clk,
    input wire logic rst,
    input wire gds_pkg::gds_bus_req_t bus,
    output logic [gds_pkg::GDS_DATA_W-1:0] rd_data,
    input wire logic [gds_pkg::GDS_SER_WIDTH-1:0] drive_word,
    input wire logic drive_enable,
    input wire logic negative_leg_drive_enable,
    input wire logic second_drive,
    input wire logic second_drive_enable,
    input wire logic delay_step_enable,
    input wire logic delay_step_direction,
    input wire logic delay_counter_reset,
    output logic [gds_pkg::GDS_SER_WIDTH-1:0] sample_word,
    output logic second_sample,
    output logic bypass_input_tap,
    output logic [gds_pkg::GDS_BYP_TARGETS-1:0] bypass_route,
    input wire logic pad_p_in,
    input wire logic pad_n_in,
    output gds_pkg::gds_pad_drive_t pads
);
    import gds_pkg::*;

    function automatic logic [5:0] clamp_steps(input logic [5:0] v, input logic wide);
        clamp_steps = (!wide && v > GDS_NARROW_MAX) ? GDS_NARROW_MAX : v;
    endfunction : clamp_steps

    gds_cfg_t cfg;
    gds_dly_t dly;
    logic phase;
    logic [1:0] ser_count;
    logic [5:0] dyn_cnt;
    logic [GDS_IN_LINE_DEPTH-2:0] in_line;
    logic [GDS_OUT_LINE_DEPTH-2:0] out_line;
    logic out_q;
    logic oe_q;
    logic ddr_hold;
    logic fall_hold;
    logic [GDS_SER_WIDTH-2:0] ser_shift;
    logic [GDS_SER_WIDTH-1:0] des_shift;

    logic diff_eff;
    logic dyn_on;
    gds_mode_t eff_mode;
    logic [5:0] in_static_eff;
    logic [5:0] out_static_eff;
    logic [6:0] in_tap;
    logic conflict;
    logic din;
    logic dout;
    logic launch_edge;
    logic capture_edge;
    logic bypass_ok;
    logic [GDS_IN_LINE_DEPTH-1:0] in_taps;
    logic [GDS_OUT_LINE_DEPTH-1:0] out_taps;

    // differential use exists only on the high-speed pair
    assign diff_eff = cfg.diff & cfg.high_speed;
    // dynamic chain only on the high-speed input path
    assign dyn_on = cfg.dyn_delay_en & cfg.high_speed;
    // serdes is full rate only and missing on the high-voltage pad
    assign eff_mode = (cfg.mode == GDS_MODE_SERDES && !cfg.high_speed) ? GDS_MODE_SINGLE : cfg.mode;
    // narrow pads clamp static settings to 16 steps
    assign in_static_eff = clamp_steps(dly.in_static, diff_eff);
    // differential transmit gets the full 64-step output chain
    assign out_static_eff = clamp_steps(dly.out_static, diff_eff);
    assign conflict = diff_eff & dyn_on & (dly.in_static != 6'h00);

    // on a differential receiver the dynamic setting replaces the static one
    always_comb begin
        if (diff_eff) begin
            in_tap = dyn_on ? {1'b0, dyn_cnt} : {1'b0, in_static_eff};
        end else begin
            in_tap = {1'b0, in_static_eff} + (dyn_on ? {1'b0, dyn_cnt} : 7'h00);
        end
    end

    // only the positive leg passes through the delay chains
    assign in_taps = {in_line, pad_p_in};
    assign din = in_taps[in_tap];
    assign out_taps = {out_line, out_q};
    assign dout = out_taps[out_static_eff];

    // launch and capture edges are the alternating clk phases
    // each register picks its own edge
    assign launch_edge = cfg.out_fall ? phase : !phase;
    assign capture_edge = cfg.in_fall ? phase : !phase;

    // high-voltage bypass feeds the synthesizer reference only
    // high-speed bypass may feed any of the five targets
    assign bypass_ok = (cfg.mode == GDS_MODE_BYPASS) && !cfg.in_reg &&
        (cfg.high_speed ? (cfg.bypass_target <= GDS_BYP_VREF)
                        : (cfg.bypass_target == GDS_BYP_SYNTH_REF));

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg <= GDS_CFG_RESET;
            dly <= GDS_DLY_RESET;
        end else if (bus.wr) begin
            if (bus.addr == GDS_CFG_ADDR) begin
                cfg <= gds_cfg_t'(bus.wr_data[15:0]);
            end
            if (bus.addr == GDS_DLY_ADDR) begin
                dly <= gds_dly_t'(bus.wr_data[21:0] & GDS_DLY_WMASK);
            end
        end
    end

    // Unmapped addresses read zero; data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= '0;
        end else if (bus.rd) begin
            case (bus.addr)
                GDS_CFG_ADDR: rd_data <= {16'h0000, cfg};
                GDS_DLY_ADDR: rd_data <= {10'h000, dly};
                GDS_STAT_ADDR: rd_data <= {14'h0000, bypass_ok, conflict, 2'h0, dyn_cnt,
                    1'b0, in_tap};
                default: rd_data <= '0;
            endcase
        end else begin
            rd_data <= '0;
        end
    end

    // the serdes counters run on clk, which stands for both fast clocks
    always_ff @(posedge clk) begin
        if (rst) begin
            phase <= 1'b0;
            ser_count <= 2'h0;
        end else begin
            phase <= !phase;
            ser_count <= ser_count + 2'h1;
        end
    end

    // the delay moves only while enabled, up on 1 and down on 0
    // the delay reset restores the programmed start step
    // inputs sampled on the edge, so at most one step per cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            dyn_cnt <= 6'h00;
        end else if (delay_counter_reset) begin
            dyn_cnt <= dly.dyn_init;
        end else if (delay_step_enable) begin
            if (delay_step_direction) begin
                dyn_cnt <= (dyn_cnt == GDS_WIDE_MAX) ? dyn_cnt : dyn_cnt + 6'h01;
            end else begin
                dyn_cnt <= (dyn_cnt == 6'h00) ? dyn_cnt : dyn_cnt - 6'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            in_line <= '0;
            out_line <= '0;
        end else begin
            in_line <= in_taps[GDS_IN_LINE_DEPTH-2:0];
            out_line <= out_taps[GDS_OUT_LINE_DEPTH-2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            out_q <= 1'b0;
            ddr_hold <= 1'b0;
            ser_shift <= '0;
        end else begin
            case (eff_mode)
                // bit 0 at the rising launch edge, bit 1 at the falling one
                GDS_MODE_DOUBLE: begin
                    if (!phase) begin
                        out_q <= drive_word[0] ^ cfg.out_invert;
                        ddr_hold <= drive_word[1];
                    end else begin
                        out_q <= ddr_hold ^ cfg.out_invert;
                    end
                end
                // bit 0 leaves first, bit 3 last
                GDS_MODE_SERDES: begin
                    if (ser_count == 2'h0) begin
                        out_q <= drive_word[0];
                        ser_shift <= drive_word[3:1];
                    end else begin
                        out_q <= ser_shift[0];
                        ser_shift <= {1'b0, ser_shift[2:1]};
                    end
                end
                default: begin
                    // plain output comes from bit zero
                    if (!cfg.out_reg) begin
                        out_q <= drive_word[0];
                    end else if (launch_edge) begin
                        out_q <= drive_word[0] ^ cfg.out_invert;
                    end
                end
            endcase
        end
    end

    // enable is either registered on the launch edge or followed each cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            oe_q <= 1'b0;
        end else if (!cfg.oe_reg || (cfg.oe_fall ? phase : !phase)) begin
            oe_q <= drive_enable;
        end
    end

    // Pad drive; the negative leg follows its own enable so a bad core drive shows on the pin
    always_ff @(posedge clk) begin
        if (rst) begin
            pads <= '0;
            second_sample <= 1'b0;
        end else begin
            pads.p_out <= dout;
            pads.p_oe <= oe_q;
            second_sample <= cfg.high_speed & !diff_eff & pad_n_in;
            if (diff_eff) begin
                pads.n_out <= !dout;
                // core drives this enable the same as the positive one
                pads.n_oe <= negative_leg_drive_enable;
            end else if (cfg.high_speed) begin
                // the negative pin is an independent plain pin
                pads.n_out <= second_drive;
                pads.n_oe <= second_drive_enable;
            end else begin
                pads.n_out <= 1'b0;
                pads.n_oe <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sample_word <= '0;
            fall_hold <= 1'b0;
            des_shift <= '0;
        end else begin
            des_shift <= {din, des_shift[3:1]};
            case (eff_mode)
                // rise sample on bit 0, fall sample on bit 1
                GDS_MODE_DOUBLE: begin
                    if (!phase) begin
                        sample_word[0] <= din;
                        // the held fall sample joins the rising edge
                        if (cfg.resync) begin
                            sample_word[1] <= fall_hold;
                        end
                    end else if (cfg.resync) begin
                        fall_hold <= din;
                    end else begin
                        sample_word[1] <= din;
                    end
                end
                // earliest bit lands in bit 0
                GDS_MODE_SERDES: begin
                    if (ser_count == 2'h3) begin
                        sample_word <= {din, des_shift[3:1]};
                    end
                end
                GDS_MODE_BYPASS: sample_word <= '0;
                default: begin
                    // plain input lands on bit zero
                    if (!cfg.in_reg || capture_edge) begin
                        sample_word <= {3'h0, din};
                    end
                end
            endcase
        end
    end

    // bypass tap never passes through an input register
    always_ff @(posedge clk) begin
        if (rst) begin
            bypass_input_tap <= 1'b0;
            bypass_route <= '0;
        end else begin
            bypass_input_tap <= bypass_ok & din;
            bypass_route <= bypass_ok ? GDS_BYP_TARGETS'(5'h01 << cfg.bypass_target) : '0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    dly_sat_top_a: assert property (
        (dyn_cnt == GDS_WIDE_MAX && delay_step_enable && delay_step_direction
            && !delay_counter_reset) |=> dyn_cnt == GDS_WIDE_MAX)
        else $error("dynamic delay wrapped past top");
    dly_sat_low_a: assert property (
        (dyn_cnt == 6'h00 && delay_step_enable && !delay_step_direction
            && !delay_counter_reset) |=> dyn_cnt == 6'h00)
        else $error("dynamic delay wrapped below zero");
    dly_step_up_a: assert property (
        (delay_step_enable && delay_step_direction && !delay_counter_reset
            && dyn_cnt != GDS_WIDE_MAX) |=> dyn_cnt == $past(dyn_cnt) + 6'h01)
        else $error("dynamic delay step not exactly one");
    dly_idle_hold_a: assert property (
        (!delay_step_enable && !delay_counter_reset) |=> $stable(dyn_cnt))
        else $error("dynamic delay moved while disabled");
    dly_reset_init_a: assert property (
        delay_counter_reset |=> dyn_cnt == $past(dly.dyn_init))
        else $error("delay reset did not restore start step");
    narrow_limit_a: assert property (
        !diff_eff |-> (in_static_eff <= GDS_NARROW_MAX && out_static_eff <= GDS_NARROW_MAX))
        else $error("narrow static delay above 16 steps");
    diff_excl_a: assert property (
        (diff_eff && dyn_on) |-> in_tap == {1'b0, dyn_cnt})
        else $error("static delay mixed into dynamic receive");
    ser_last_bit_a: assert property (
        (eff_mode == GDS_MODE_SERDES && ser_count == 2'h0)
            ##1 (eff_mode == GDS_MODE_SERDES) [*3] |=> out_q == $past(drive_word[3], 4))
        else $error("serializer bit 3 not sent last");
    des_first_bit_a: assert property (
        (eff_mode == GDS_MODE_SERDES && ser_count == 2'h3) |=> sample_word[0] == $past(din, 4))
        else $error("deserializer bit 0 not earliest");
    ddr_rise_in_a: assert property (
        (eff_mode == GDS_MODE_DOUBLE && !phase) |=> sample_word[0] == $past(din))
        else $error("double rate rise sample misplaced");
    oe_launch_a: assert property (
        (cfg.oe_reg && !cfg.oe_fall && phase) |=> $stable(oe_q))
        else $error("registered enable changed off launch edge");
    hv_bypass_a: assert property (
        (!cfg.high_speed && $past(!cfg.high_speed) && bypass_route != '0)
            |-> bypass_route == GDS_BYP_TARGETS'(5'h01 << GDS_BYP_SYNTH_REF))
        else $error("high-voltage bypass reached a forbidden target");
endmodule : gds_pad_logic

//--- gds_core_model.sv
// Core-fabric stand-in for the pad logic: streams a fixed bit pattern into the drive word.
// Assumes one clock shared with the pad logic and a synchronous active-high reset.
module gds_core_model #(
    parameter logic [31:0] PAT = 32'h0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic lone,
    input wire logic oe_req,
    output logic [3:0] drive_word,
    output logic drive_enable,
    output logic negative_leg_drive_enable,
    output logic [4:0] cyc
);
    timeunit 1ns;
    timeprecision 1ps;

    assign drive_enable = oe_req;
    assign negative_leg_drive_enable = oe_req;

    // Lone mode sets the upper bits against bit 0, so only bit 0 can explain the pad
    always @(posedge clk) begin
        if (rst) begin
            cyc <= 5'h0;
            drive_word <= 4'h0;
        end else begin
            cyc <= cyc + 5'h1;
            if (lone) begin
                drive_word <= {{3{~PAT[cyc]}}, PAT[cyc]};
            end else begin
                drive_word <= {PAT[cyc + 5'h3], PAT[cyc + 5'h2], PAT[cyc + 5'h1], PAT[cyc]};
            end
        end
    end
endmodule : gds_core_model

//--- gds_pad_logic_bench.sv
// Self-checking bench for the pad logic: register port tasks and pattern streams.
// Assumes the core model beside it and a pad that reads back whatever is driven on it.
module gds_pad_logic_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import gds_pkg::*;

    localparam logic [31:0] PAT = 32'h0ed3_6a59;
    logic clk = 1'b0;
    logic rst = 1'b1;
    gds_bus_req_t bus = '0;
    logic [31:0] rd_data;
    logic [3:0] drive_word;
    logic [3:0] sample_word;
    logic drive_enable, negative_leg_drive_enable, second_sample, bypass_input_tap;
    logic delay_step_enable = 1'b0;
    logic delay_step_direction = 1'b0;
    logic delay_counter_reset = 1'b0;
    logic [4:0] bypass_route;
    logic pad_p_in, pad_n_in;
    logic pad_ext = 1'b0;
    gds_pad_drive_t pads;
    logic lone = 1'b1;
    logic oe_req = 1'b0;
    logic [4:0] cyc;
    logic [31:0] v;
    int errors = 0;
    int checked = 0;
    int ticks = 0;
    int d0, di0, d, n;

    always #5 clk = ~clk;

    gds_pad_logic u_dut (
        .clk(clk), .rst(rst), .bus(bus), .rd_data(rd_data), .drive_word(drive_word),
        .drive_enable(drive_enable), .negative_leg_drive_enable(negative_leg_drive_enable),
        .second_drive(lone), .second_drive_enable(oe_req),
        .delay_step_enable(delay_step_enable), .delay_step_direction(delay_step_direction),
        .delay_counter_reset(delay_counter_reset), .sample_word(sample_word),
        .second_sample(second_sample), .bypass_input_tap(bypass_input_tap),
        .bypass_route(bypass_route), .pad_p_in(pad_p_in), .pad_n_in(pad_n_in), .pads(pads)
    );

    gds_core_model #(.PAT(PAT)) u_core (
        .clk(clk), .rst(rst), .lone(lone), .oe_req(oe_req), .drive_word(drive_word),
        .drive_enable(drive_enable), .negative_leg_drive_enable(negative_leg_drive_enable),
        .cyc(cyc)
    );

    // The pad shows the device's level while it drives, the outside pattern otherwise
    assign pad_p_in = pads.p_oe ? pads.p_out : pad_ext;
    assign pad_n_in = pads.n_oe ? pads.n_out : ~pad_ext;

    always @(posedge clk) begin
        pad_ext <= PAT[cyc];
    end

    always @(posedge clk) begin
        ticks++;
        if (ticks == 4000) begin
            errors++;
            summarize();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    task automatic wr(input logic [3:0] a, input logic [31:0] data);
        @(posedge clk);
        bus.addr <= a;
        bus.wr_data <= data;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] data);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        data = rd_data;
    endtask : rd

    function automatic logic [31:0] cfgw(gds_mode_t m, logic hs, logic df, logic ir,
                                         logic orr, logic dy, logic [2:0] t);
        return {16'h0, t, dy, 6'h0, orr, ir, df, hs, m};
    endfunction : cfgw

    function automatic logic [31:0] dlyw(logic [5:0] i, logic [5:0] o, logic [5:0] s);
        return {10'h0, s, 2'h0, o, 2'h0, i};
    endfunction : dlyw

    task automatic setup(input logic [31:0] c, input logic [31:0] dl);
        wr(GDS_CFG_ADDR, c);
        wr(GDS_DLY_ADDR, dl);
    endtask : setup

    task automatic step(input logic dir, input int cnt);
        @(posedge clk);
        delay_step_enable <= 1'b1;
        delay_step_direction <= dir;
        repeat (cnt) @(posedge clk);
        delay_step_enable <= 1'b0;
    endtask : step

    // Latency is found by sliding the known pattern; a wrong bit order matches nowhere
    task automatic measure(input int w, input logic inp, input logic ln,
                           output int bd, output int bn);
        logic [3:0] rec [48];
        logic [4:0] rc [48];
        logic [3:0] e;
        int m;
        @(posedge clk);
        oe_req <= ~inp;
        lone <= ln;
        repeat (16) @(posedge clk);
        for (int c = 0; c < 48; c++) begin
            @(posedge clk);
            #1;
            rec[c] = inp ? sample_word : {3'h0, pads.p_out};
            rc[c] = cyc;
        end
        bn = -1;
        bd = 0;
        for (int k = 0; k < 32; k++) begin
            m = 0;
            for (int c = 0; c < 48; c++) begin
                for (int i = 0; i < 4; i++) begin
                    e[i] = (i < w) ? PAT[5'(rc[c] - k + i)] : rec[c][i];
                end
                if (e === rec[c]) m++;
            end
            if (m > bn) begin
                bn = m;
                bd = k;
            end
        end
    endtask : measure

    task automatic byp(input logic [31:0] c);
        wr(GDS_CFG_ADDR, c);
        repeat (4) @(posedge clk);
        #1;
    endtask : byp

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(GDS_CFG_ADDR, v);
        check(v, 32'h0);
        rd(GDS_STAT_ADDR, v);
        check(v, 32'h0);
        wr(4'hc, 32'hffff_ffff);
        rd(4'hc, v);
        check(v, 32'h0);
        wr(GDS_DLY_ADDR, 32'hffff_ffff);
        rd(GDS_DLY_ADDR, v);
        check(v, 32'h003f_3f3f);
        @(posedge clk);
        #1;
        check(rd_data, 32'h0);
        // Unregistered paths follow every clk; registered ones move only on alternate edges
        setup(cfgw(GDS_MODE_SINGLE, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0), dlyw(0, 0, 0));
        measure(1, 1'b0, 1'b1, d0, n);
        check(32'(n), 32'd48);
        check({30'h0, pads.n_oe, second_sample}, 32'h3);
        measure(1, 1'b1, 1'b1, di0, n);
        check(32'(n), 32'd48);
        wr(GDS_DLY_ADDR, dlyw(4, 7, 0));
        measure(1, 1'b0, 1'b1, d, n);
        check(32'(d - d0), 32'd7);
        measure(1, 1'b1, 1'b1, d, n);
        check(32'(d - di0), 32'd4);
        setup(cfgw(GDS_MODE_SINGLE, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0), dlyw(0, 0, 0));
        step(1'b1, 3);
        rd(GDS_STAT_ADDR, v);
        check(32'(v[13:8]), 32'd3);
        @(posedge clk);
        delay_step_direction <= 1'b1;
        repeat (4) @(posedge clk);
        rd(GDS_STAT_ADDR, v);
        check(32'(v[13:8]), 32'd3);
        measure(1, 1'b1, 1'b1, d, n);
        check(32'(d - di0), 32'd3);
        measure(1, 1'b0, 1'b1, d, n);
        check(32'(d), 32'(d0));
        step(1'b0, 5);
        rd(GDS_STAT_ADDR, v);
        check(32'(v[13:8]), 32'd0);
        wr(GDS_DLY_ADDR, dlyw(0, 0, 62));
        @(posedge clk);
        delay_counter_reset <= 1'b1;
        @(posedge clk);
        delay_counter_reset <= 1'b0;
        rd(GDS_STAT_ADDR, v);
        check(32'(v[13:8]), 32'd62);
        step(1'b1, 3);
        rd(GDS_STAT_ADDR, v);
        check(32'(v[13:8]), 32'd63);
        setup(cfgw(GDS_MODE_DOUBLE, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 3'h0), dlyw(0, 0, 0));
        measure(1, 1'b0, 1'b0, d, n);
        check(32'(n), 32'd48);
        measure(2, 1'b1, 1'b0, d, n);
        check(32'(n >= 24), 32'h1);
        wr(GDS_CFG_ADDR, cfgw(GDS_MODE_SERDES, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 3'h0));
        measure(1, 1'b0, 1'b0, d, n);
        check(32'(n), 32'd48);
        measure(4, 1'b1, 1'b0, d, n);
        check(32'(n >= 12), 32'h1);
        // Registered enable, so the launch-edge hold of the enable is exercised
        setup(cfgw(GDS_MODE_SINGLE, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0) | 32'h0000_0040,
              dlyw(1, 0, 0));
        rd(GDS_STAT_ADDR, v);
        check(32'(v[16]), 32'h1);
        measure(1, 1'b0, 1'b1, d, n);
        check({31'h0, pads.n_out}, {31'h0, ~pads.p_out});
        check({31'h0, pads.n_oe}, {31'h0, pads.p_oe});
        for (int k = 0; k < GDS_BYP_TARGETS; k++) begin
            byp(cfgw(GDS_MODE_BYPASS, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'(k)));
            check({27'h0, bypass_route}, 32'(1 << k));
        end
        byp(cfgw(GDS_MODE_BYPASS, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, GDS_BYP_GLOBAL));
        check({27'h0, bypass_route}, 32'h0);
        check({31'h0, bypass_input_tap}, 32'h0);
        byp(cfgw(GDS_MODE_BYPASS, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, GDS_BYP_SYNTH_REF));
        check({27'h0, bypass_route}, 32'h4);
        byp(cfgw(GDS_MODE_BYPASS, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, GDS_BYP_GLOBAL));
        check({27'h0, bypass_route}, 32'h0);
        check({31'h0, bypass_input_tap}, 32'h0);
        summarize();
    end
endmodule : gds_pad_logic_bench
